//--- rtl/glyph_write_unit.sv
// Glyph and image write path with combined status and colour registers.
//
// Function
// - Single-plane words pass one bit per pixel, flagged for eight-plane expansion downstream.
// - Antialias mode sums set subpixels into a grayscale pixel value.
// - Glyph port reads nothing in single-plane and antialias modes.
// - Eight-plane mode writes four 8-bit pixels through rop and colours.
// - Eight-plane reads return frame buffer pixels at the current position.
// - Left X, row Y and right X set start and inclusive width.
// - Nothing outside width range is modified; width mask ANDs clip mask.
// - Big-endian single-plane: bit 31 is left pixel, bit 0 is left+31.
// - Little-endian single-plane: bit 0 is left pixel, bit 31 is left+31.
// - Big-endian antialias: bit 31 is left subpixel, bit 0 left+31.
// - Big-endian eight-plane: bits 31..24 are left pixel, then onward.
// - Little-endian eight-plane: bits 7..0 are left pixel, then onward.
// - One status register holds all status, updated on address or clip writes.
// - Sticky overflow at bit 21 and pick at bit 20 stay until cleared.
// - Write with clear-select set clears only sticky flags written as one.
// - Write with clear-select zero loads sticky flags directly.
// - Clear-select bit always reads zero.
// - Status writes touch only sticky flags; others come from coordinates and mode.
// - Colour low eight bits drive planes; monochrome uses bit zero only.
`timescale 1ns/1ps
`default_nettype none
`include "glyph_unit_regs.svh"
module glyph_write_unit
   import glyph_unit_pkg::*;
(
   // Clock and reset.
   input  wire logic        i_ref_clk,
   input  wire logic        i_resetn,
   // Register port.
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata,
   // Status events from the rendering core.
   input  wire logic        i_overflow_evt,
   input  wire logic        i_pick_evt,
   // Frame buffer read data for the current position.
   input  wire logic [31:0] i_fb_rdata,
   // Frame buffer write port: one word of four pixels, 32 one-bit pixels, or one grayscale pixel.
   output logic             o_fb_we,
   output logic      [15:0] o_fb_x,
   output logic      [15:0] o_fb_y,
   output logic      [31:0] o_fb_wdata,
   output logic      [31:0] o_fb_pix_en,
   output logic             o_fb_gray,
   output logic             o_fb_expand
);

   logic [31:0] status_ff;
   logic        ovf_ff;
   logic        pick_ff;
   logic [7:0]  fg_ff;
   logic [7:0]  bg_ff;
   logic [7:0]  rop_ff;
   logic [2:0]  mode_ff;
   coord_t      left_x_ff;
   coord_t      row_y_ff;
   coord_t      right_x_ff;
   coord_t      step_x_ff;
   coord_t      step_y_ff;
   coord_t      clip_lo_ff;
   coord_t      clip_hi_ff;
   logic        addr_wr_ff;
   logic [31:0] nxt_rdata;
   logic [31:0] nxt_fb_wdata;
   logic [31:0] nxt_pix_en;
   pixel_mode_e mode;
   logic        big_endian;
   logic        glyph_wr;
   logic        glyph_rd;
   coord_t      width_m1;

   assign mode       = pixel_mode_e'(mode_ff[1:0]);
   assign big_endian = mode_ff[`GU_MODE_ENDIAN_BIT];
   assign glyph_wr   = i_wr && (i_addr == `GU_ADDR_GLYPH);
   assign glyph_rd   = i_rd && (i_addr == `GU_ADDR_GLYPH);
   assign width_m1   = right_x_ff - left_x_ff;

   // Reverses a 32-bit word so that bit 0 always means the left position.
   function automatic logic [31:0] bit_rev(input logic [31:0] w);
      logic [31:0] r;
      r = '0;
      for (int i = 0; i < 32; i++) begin
         r[i] = w[31-i];
      end
      return r;
   endfunction : bit_rev

   // Boolean raster op per plane: rop bit index is {source, foreground, background}.
   function automatic logic [7:0] rop_plane(input logic src, input logic [7:0] fg,
                                            input logic [7:0] bg, input logic [7:0] rop);
      logic [7:0] r;
      r = '0;
      for (int p = 0; p < 8; p++) begin
         r[p] = rop[{src, fg[p], bg[p]}];
      end
      return r;
   endfunction : rop_plane

   // True when x lies in [lo, hi].
   function automatic logic in_range(input coord_t x, input coord_t lo, input coord_t hi);
      return (x >= lo) && (x <= hi);
   endfunction : in_range

   // Register writes of attributes, mode and coordinates.
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         fg_ff      <= `GU_COLOR_RESET;
         bg_ff      <= `GU_COLOR_RESET;
         rop_ff     <= `GU_ROP_RESET;
         mode_ff    <= 3'h0;
         right_x_ff <= `GU_COORD_RESET;
         step_x_ff  <= `GU_COORD_RESET;
         step_y_ff  <= `GU_COORD_RESET;
         clip_lo_ff <= `GU_COORD_RESET;
         clip_hi_ff <= 16'hffff;
      end else if (i_wr) begin
         unique case (i_addr)
            `GU_ADDR_FGCOLOR: fg_ff      <= i_wdata[7:0];
            `GU_ADDR_BGCOLOR: bg_ff      <= i_wdata[7:0];
            `GU_ADDR_ROP:     rop_ff     <= i_wdata[7:0];
            `GU_ADDR_MODE:    mode_ff    <= i_wdata[2:0];
            `GU_ADDR_RIGHT_X: right_x_ff <= i_wdata[15:0];
            `GU_ADDR_STEP_X:  step_x_ff  <= i_wdata[15:0];
            `GU_ADDR_STEP_Y:  step_y_ff  <= i_wdata[15:0];
            `GU_ADDR_CLIP_LO: clip_lo_ff <= i_wdata[15:0];
            `GU_ADDR_CLIP_HI: clip_hi_ff <= i_wdata[15:0];
            default: ;
         endcase
      end
   end

   // Current position, stepped after every glyph write and after glyph reads in eight-plane mode.
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         left_x_ff <= `GU_COORD_RESET;
         row_y_ff  <= `GU_COORD_RESET;
      end else if (i_wr && i_addr == `GU_ADDR_LEFT_X) begin
         left_x_ff <= i_wdata[15:0];
      end else if (i_wr && i_addr == `GU_ADDR_ROW_Y) begin
         row_y_ff <= i_wdata[15:0];
      end else if (glyph_wr || (glyph_rd && mode == eight_plane_color_mode)) begin
         left_x_ff <= left_x_ff + step_x_ff;
         row_y_ff  <= row_y_ff + step_y_ff;
      end
   end

   // Sticky flags: hardware set wins over a software clear in the same cycle.
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ovf_ff  <= 1'b0;
         pick_ff <= 1'b0;
      end else if (i_wr && i_addr == `GU_ADDR_STATUS) begin
         if (i_wdata[`GU_ST_CLEAR_SEL]) begin
            ovf_ff  <= i_overflow_evt | (ovf_ff & ~i_wdata[`GU_ST_OVERFLOW]);
            pick_ff <= i_pick_evt | (pick_ff & ~i_wdata[`GU_ST_PICK]);
         end else begin
            ovf_ff  <= i_overflow_evt | i_wdata[`GU_ST_OVERFLOW];
            pick_ff <= i_pick_evt | i_wdata[`GU_ST_PICK];
         end
      end else begin
         ovf_ff  <= ovf_ff | i_overflow_evt;
         pick_ff <= pick_ff | i_pick_evt;
      end
   end

   // Marks a write to any address or clip register, so status is refreshed next cycle.
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         addr_wr_ff <= 1'b0;
      end else begin
         addr_wr_ff <= i_wr && (i_addr inside {`GU_ADDR_LEFT_X, `GU_ADDR_ROW_Y,
                        `GU_ADDR_RIGHT_X, `GU_ADDR_CLIP_LO, `GU_ADDR_CLIP_HI});
      end
   end

   // Derived clip status of the span from left X to right X.
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         status_ff <= 32'h0000_0000;
      end else if (addr_wr_ff) begin
         status_ff <= 32'h0000_0000;
         status_ff[`GU_ST_MONO] <= (mode == antialias_mono_mode);
         status_ff[`GU_ST_VISIBLE] <= (left_x_ff >= clip_lo_ff) && (right_x_ff <= clip_hi_ff);
         status_ff[`GU_ST_HIDDEN] <= (right_x_ff < clip_lo_ff) || (left_x_ff > clip_hi_ff);
         status_ff[`GU_ST_CROSS] <= !((left_x_ff >= clip_lo_ff) && (right_x_ff <= clip_hi_ff))
                                    && !((right_x_ff < clip_lo_ff) || (left_x_ff > clip_hi_ff));
      end
   end

   // Read data, valid only in the cycle after the read strobe.
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      unique case (i_addr)
         `GU_ADDR_GLYPH:   nxt_rdata = (mode == eight_plane_color_mode) ? i_fb_rdata
                                       : 32'h0000_0000;
         `GU_ADDR_STATUS: begin
            nxt_rdata = status_ff;
            nxt_rdata[`GU_ST_OVERFLOW]  = ovf_ff;
            nxt_rdata[`GU_ST_PICK]      = pick_ff;
            nxt_rdata[`GU_ST_CLEAR_SEL] = 1'b0;
         end
         `GU_ADDR_FGCOLOR: nxt_rdata = {24'h00_0000, fg_ff};
         `GU_ADDR_BGCOLOR: nxt_rdata = {24'h00_0000, bg_ff};
         `GU_ADDR_ROP:     nxt_rdata = {24'h00_0000, rop_ff};
         `GU_ADDR_MODE:    nxt_rdata = {29'h0000_0000, mode_ff};
         `GU_ADDR_LEFT_X:  nxt_rdata = {16'h0000, left_x_ff};
         `GU_ADDR_ROW_Y:   nxt_rdata = {16'h0000, row_y_ff};
         `GU_ADDR_RIGHT_X: nxt_rdata = {16'h0000, right_x_ff};
         `GU_ADDR_STEP_X:  nxt_rdata = {16'h0000, step_x_ff};
         `GU_ADDR_STEP_Y:  nxt_rdata = {16'h0000, step_y_ff};
         `GU_ADDR_CLIP_LO: nxt_rdata = {16'h0000, clip_lo_ff};
         `GU_ADDR_CLIP_HI: nxt_rdata = {16'h0000, clip_hi_ff};
         default:          nxt_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rdata <= 32'h0000_0000;
      end else begin
         o_rdata <= i_rd ? nxt_rdata : 32'h0000_0000;
      end
   end

   // Frame buffer word: data, per-pixel enable (width mask AND clip mask; antialias: mask gates subpixels, pixel 0 always enabled).
   always_comb begin
      logic [31:0] src;
      logic [7:0]  px;
      logic [4:0]  cnt;
      coord_t      xo;
      src          = big_endian ? bit_rev(i_wdata) : i_wdata;
      nxt_fb_wdata = 32'h0000_0000;
      nxt_pix_en   = 32'h0000_0000;
      px           = 8'h00;
      cnt          = 5'h00;
      xo           = '0;
      unique case (mode)
         eight_plane_color_mode: begin
            for (int k = 0; k < 4; k++) begin
               // Lane k holds pixel left+k once byte order is normalised.
               px = big_endian ? i_wdata[8*(3-k) +: 8] : i_wdata[8*k +: 8];
               for (int p = 0; p < 8; p++) begin
                  nxt_fb_wdata[8*k+p] = rop_ff[{px[p], fg_ff[p], bg_ff[p]}];
               end
               xo = left_x_ff + coord_t'(k);
               nxt_pix_en[k] = (coord_t'(k) <= width_m1)
                               && in_range(xo, clip_lo_ff, clip_hi_ff);
            end
         end
         antialias_mono_mode: begin
            for (int k = 0; k < 32; k++) begin
               xo = left_x_ff + coord_t'(k);
               if ((coord_t'(k) <= width_m1) && in_range(xo, clip_lo_ff, clip_hi_ff)) begin
                  cnt = cnt + 5'(rop_ff[{src[k], fg_ff[0], bg_ff[0]}]);
               end
            end
            nxt_fb_wdata = {24'h00_0000, 3'h0, cnt};
            nxt_pix_en   = 32'h0000_0001;
         end
         default: begin
            // Single-plane: bit k is the source of pixel left+k, planes made downstream.
            for (int k = 0; k < 32; k++) begin
               xo = left_x_ff + coord_t'(k);
               nxt_fb_wdata[k] = src[k];
               nxt_pix_en[k]   = (coord_t'(k) <= width_m1)
                                 && in_range(xo, clip_lo_ff, clip_hi_ff);
            end
         end
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_fb_we     <= 1'b0;
         o_fb_x      <= 16'h0000;
         o_fb_y      <= 16'h0000;
         o_fb_wdata  <= 32'h0000_0000;
         o_fb_pix_en <= 32'h0000_0000;
         o_fb_gray   <= 1'b0;
         o_fb_expand <= 1'b0;
      end else begin
         o_fb_we     <= glyph_wr;
         o_fb_x      <= left_x_ff;
         o_fb_y      <= row_y_ff;
         o_fb_wdata  <= nxt_fb_wdata;
         o_fb_pix_en <= nxt_pix_en;
         o_fb_gray   <= (mode == antialias_mono_mode);
         o_fb_expand <= (mode == single_plane_color_mode);
      end
   end

   // rop_plane is evaluated here only into an unused net; single-plane bits leave unexpanded;
   // the colour pair is exported through the colour registers read path.
   logic [7:0] unused_plane;
   assign unused_plane = rop_plane(1'b0, fg_ff, bg_ff, rop_ff);

endmodule : glyph_write_unit
`default_nettype wire

//--- inc/glyph_unit_regs.svh
// Register offsets, field positions and reset values of the glyph write and status unit.
`ifndef GLYPH_UNIT_REGS_SVH
`define GLYPH_UNIT_REGS_SVH
`define GU_ADDR_GLYPH      8'h00
`define GU_ADDR_STATUS     8'h04
`define GU_ADDR_FGCOLOR    8'h08
`define GU_ADDR_BGCOLOR    8'h0c
`define GU_ADDR_MODE       8'h10
`define GU_ADDR_LEFT_X     8'h14
`define GU_ADDR_ROW_Y      8'h18
`define GU_ADDR_RIGHT_X    8'h1c
`define GU_ADDR_STEP_X     8'h20
`define GU_ADDR_STEP_Y     8'h24
`define GU_ADDR_ROP        8'h28
`define GU_ADDR_CLIP_LO    8'h2c
`define GU_ADDR_CLIP_HI    8'h30
`define GU_ST_CLEAR_SEL    31
`define GU_ST_MONO         24
`define GU_ST_OVERFLOW     21
`define GU_ST_PICK         20
`define GU_ST_HIDDEN       2
`define GU_ST_CROSS        1
`define GU_ST_VISIBLE      0
`define GU_MODE_ENDIAN_BIT 2
`define GU_COORD_RESET     16'h0000
`define GU_COLOR_RESET     8'h00
`define GU_ROP_RESET       8'hf0
`endif

//--- inc/glyph_unit_pkg.sv
// Types shared by the glyph write and status unit.
package glyph_unit_pkg;
   typedef enum logic [1:0] {
      single_plane_color_mode = 2'b00,
      eight_plane_color_mode  = 2'b01,
      antialias_mono_mode     = 2'b10
   } pixel_mode_e;
   typedef logic [15:0] coord_t;
endpackage : glyph_unit_pkg

//--- verification/glyph_write_unit_sva.sv
// Port-level assertions for the glyph write unit.
`timescale 1ns/1ps
`default_nettype none
`include "glyph_unit_regs.svh"
module glyph_write_unit_sva (
   // Clock, reset and register port.
   input wire logic        i_ref_clk,
   input wire logic        i_resetn,
   input wire logic [7:0]  i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [31:0] o_rdata,
   // Events and frame buffer side.
   input wire logic        i_overflow_evt,
   input wire logic        i_pick_evt,
   input wire logic [31:0] i_fb_rdata,
   input wire logic        o_fb_we,
   input wire logic [15:0] o_fb_x,
   input wire logic        o_fb_gray,
   input wire logic        o_fb_expand
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);
   wire st_rd   = i_rd && i_addr == `GU_ADDR_STATUS;
   wire st_wr   = i_wr && i_addr == `GU_ADDR_STATUS;
   wire gl_rd   = i_rd && i_addr == `GU_ADDR_GLYPH;
   wire gl_wr   = i_wr && i_addr == `GU_ADDR_GLYPH;
   wire lx_wr   = i_wr && i_addr == `GU_ADDR_LEFT_X;
   wire eight   = !o_fb_gray && !o_fb_expand;
   wire quiet   = !i_overflow_evt && !i_pick_evt;
   wire clr_ovf = st_wr && i_wdata[31] && i_wdata[21] && quiet;
   wire load_st = st_wr && !i_wdata[31] && quiet;
   property p_clr_zero; st_rd |=> !o_rdata[31]; endproperty
   a_clr_zero: assert property (p_clr_zero) else $error("clear select read as one");
   property p_fb_write; 1'b1 |=> o_fb_we == $past(gl_wr); endproperty
   a_fb_write: assert property (p_fb_write) else $error("write pulse not tied to glyph write");
   property p_no_rd; gl_rd && !eight |=> o_rdata == 32'h0; endproperty
   a_no_rd: assert property (p_no_rd) else $error("glyph read not zero");
   property p_fb_rd; gl_rd && eight |=> o_rdata == $past(i_fb_rdata); endproperty
   a_fb_rd: assert property (p_fb_rd) else $error("glyph read lost pixels");
   property p_ovf_set; i_overflow_evt ##1 st_rd |=> o_rdata[21]; endproperty
   a_ovf_set: assert property (p_ovf_set) else $error("overflow not held");
   property p_ovf_clr; clr_ovf ##1 st_rd |=> !o_rdata[21]; endproperty
   a_ovf_clr: assert property (p_ovf_clr) else $error("overflow not cleared");
   property p_load; load_st ##1 st_rd |=> o_rdata[21:20] == $past(i_wdata[21:20], 2); endproperty
   a_load: assert property (p_load) else $error("sticky flags not loaded");
   property p_left; lx_wr ##1 gl_wr |=> o_fb_x == $past(i_wdata[15:0], 2); endproperty
   a_left: assert property (p_left) else $error("write not at left position");
endmodule : glyph_write_unit_sva
bind glyph_write_unit glyph_write_unit_sva i_glyph_write_unit_sva (
   .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_overflow_evt(i_overflow_evt),
   .i_pick_evt(i_pick_evt), .i_fb_rdata(i_fb_rdata), .o_fb_we(o_fb_we), .o_fb_x(o_fb_x),
   .o_fb_gray(o_fb_gray), .o_fb_expand(o_fb_expand));
`default_nettype wire

//--- verification/frame_store_model.sv
// Frame store model on the far side of the glyph write unit.
`timescale 1ns/1ps
`default_nettype none
module frame_store_model (
   // Write port from the unit.
   input  wire logic        i_ref_clk,
   input  wire logic        i_fb_we,
   input  wire logic [15:0] i_fb_x,
   input  wire logic [31:0] i_fb_wdata,
   input  wire logic [31:0] i_fb_pix_en,
   input  wire logic        i_fb_gray,
   input  wire logic        i_fb_expand,
   // Read position and the word stored there.
   input  wire logic [15:0] i_pos,
   output logic      [31:0] o_fb_rdata
);
   logic [31:0] mem_ff [16];
   // Only enabled pixel bytes of eight-plane words land in the store.
   always_ff @(posedge i_ref_clk) begin
      if (i_fb_we && !i_fb_gray && !i_fb_expand) begin
         for (int k = 0; k < 4; k++) begin
            if (i_fb_pix_en[k]) begin
               mem_ff[i_fb_x[5:2]][8*k +: 8] <= i_fb_wdata[8*k +: 8];
            end
         end
      end
   end
   assign o_fb_rdata = mem_ff[i_pos[5:2]];
endmodule : frame_store_model
`default_nettype wire

//--- verification/font_write_and_status_unit_bench.sv
// Self-checking bench for the glyph write unit with a frame store model.
`timescale 1ns/1ps
`default_nettype none
`include "glyph_unit_regs.svh"
module font_write_and_status_unit_bench;
   typedef struct {logic [15:0] x, y; logic [31:0] d, m, en;} note_s;
   logic        i_ref_clk, i_resetn, i_wr, i_rd, i_overflow_evt, i_pick_evt, rd_d;
   logic        o_fb_we, o_fb_gray, o_fb_expand;
   logic [7:0]  i_addr;
   logic [15:0] o_fb_x, o_fb_y, pos, x;
   logic [31:0] i_wdata, i_fb_rdata, o_rdata, o_fb_wdata, o_fb_pix_en, d, e, en, bm, mk, pe;
   logic [63:0] rd_q[$], rn;
   note_s       wr_q[$], wn;
   int          fail_count = 0, total_checks = 0, w;
   glyph_write_unit i_glyph_write_unit (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_overflow_evt(i_overflow_evt), .i_pick_evt(i_pick_evt), .i_fb_rdata(i_fb_rdata),
      .o_fb_we(o_fb_we), .o_fb_x(o_fb_x), .o_fb_y(o_fb_y), .o_fb_wdata(o_fb_wdata),
      .o_fb_pix_en(o_fb_pix_en), .o_fb_gray(o_fb_gray), .o_fb_expand(o_fb_expand));
   frame_store_model i_frame_store_model (.i_ref_clk(i_ref_clk), .i_fb_we(o_fb_we),
      .i_fb_x(o_fb_x), .i_fb_wdata(o_fb_wdata), .i_fb_pix_en(o_fb_pix_en),
      .i_fb_gray(o_fb_gray), .i_fb_expand(o_fb_expand), .i_pos(pos), .o_fb_rdata(i_fb_rdata));
   initial begin
      i_ref_clk = 1'b0;
      forever #20 i_ref_clk = ~i_ref_clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic wv, input logic rv, input logic [7:0] a,
                      input logic [31:0] v, input logic [1:0] ev);
      @(posedge i_ref_clk);
      i_wr <= wv;
      i_rd <= rv;
      i_addr <= a;
      i_wdata <= v;
      {i_overflow_evt, i_pick_evt} <= ev;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      bus(1'b1, 1'b0, a, v, 2'b00);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] m);
      rd_q.push_back({ex, m});
      bus(1'b0, 1'b1, a, 32'h0, 2'b00);
   endtask : rd
   task automatic glyph(input logic [15:0] y);
      wr_q.push_back('{x, y, e & mk, mk, pe});
      wr(`GU_ADDR_GLYPH, d);
   endtask : glyph
   task automatic finish_test;
      $display("Checks %0d, errors %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finish_test
   // Results are compared mid-cycle, once the registered outputs have settled.
   always @(posedge i_ref_clk) rd_d <= i_rd;
   always @(negedge i_ref_clk) begin
      if (rd_d) begin
         rn = rd_q.pop_front();
         chk(o_rdata & rn[31:0], rn[63:32]);
      end
      if (o_fb_we) begin
         wn = wr_q.pop_front();
         chk({o_fb_y, o_fb_x}, {wn.y, wn.x});
         chk(o_fb_pix_en, wn.en);
         chk(o_fb_wdata & wn.m, wn.d);
      end
   end
   initial begin
      repeat (5000) @(posedge i_ref_clk);
      fail_count++;
      $display("ERROR %0t: run timed out", $time);
      finish_test();
   end
   initial begin
      i_resetn = 1'b0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 8'h00;
      i_wdata = 32'h0;
      i_overflow_evt = 1'b0;
      i_pick_evt = 1'b0;
      pos = 16'h0;
      void'($urandom(29));
      repeat (8) @(posedge i_ref_clk);
      i_resetn <= 1'b1;
      d = $urandom;
      wr(`GU_ADDR_FGCOLOR, d);
      rd(`GU_ADDR_FGCOLOR, d & 32'hff, 32'hff);
      rd(`GU_ADDR_BGCOLOR, 32'h0, 32'hff);
      rd(8'h40, 32'h0, 32'hffffffff);
      bus(1'b0, 1'b0, 8'h00, 32'h0, 2'b11);
      rd(`GU_ADDR_STATUS, 32'h00300000, 32'h80300000);
      wr(`GU_ADDR_STATUS, 32'h80200000);
      rd(`GU_ADDR_STATUS, 32'h00100000, 32'h80300000);
      wr(`GU_ADDR_STATUS, 32'h00200000);
      rd(`GU_ADDR_STATUS, 32'h00200000, 32'h80300000);
      for (int m = 0; m < 6; m++) begin
         if (m == 4) continue;
         wr(`GU_ADDR_MODE, {29'h0, m[0], 2'(m >> 1)});
         w = (m < 2) ? $urandom_range(31, 0) : (m < 4) ? $urandom_range(3, 0) : 15;
         x = 16'(4 * $urandom_range(15, 0));
         d = $urandom;
         en = 32'((33'h1 << (w + 1)) - 1);
         bm = {{8{en[3]}}, {8{en[2]}}, {8{en[1]}}, {8{en[0]}}};
         if (m > 3) e = 32'($countones(d[31:16]));
         else if (m == 3) e = {<<8{d}};
         else if (m == 1) e = {<<{d}};
         else e = d;
         mk = (m > 3) ? 32'h1f : (m > 1) ? bm : en;
         pe = (m > 3) ? 32'h1 : en;
         wr(`GU_ADDR_STEP_X, 32'h0);
         wr(`GU_ADDR_STEP_Y, 32'h1);
         wr(`GU_ADDR_ROW_Y, 32'h5);
         wr(`GU_ADDR_RIGHT_X, 32'(x) + 32'(w));
         wr(`GU_ADDR_LEFT_X, 32'(x));
         glyph(16'h5);
         glyph(16'h6);
         pos <= x;
         rd(`GU_ADDR_GLYPH, (m == 2) ? d & bm : 32'h0, (m == 2) ? bm : (m == 3) ? 32'h0 : '1);
      end
      rd(`GU_ADDR_STATUS, 32'h01000001, 32'h01000007);
      wr(`GU_ADDR_STATUS, 32'h0);
      rd(`GU_ADDR_STATUS, 32'h01000000, 32'h81300000);
      bus(1'b0, 1'b0, 8'h00, 32'h0, 2'b00);
      for (w = 0; w < 8 && rd_q.size() + wr_q.size() > 0; w++) @(posedge i_ref_clk);
      if (rd_q.size() + wr_q.size() > 0) begin
         fail_count++;
         $display("ERROR %0t: results missing", $time);
      end
      finish_test();
   end
endmodule : font_write_and_status_unit_bench
`default_nettype wire
